// *** design/spcm_pkg.sv ***
// Constants for the EEPROM-to-configuration-space field loader
package spcm_pkg;
  // EEPROM word addresses
  localparam logic [7:0] EE_SLOT_P0 = 8'h60;
  localparam logic [7:0] EE_SLOT_P1 = 8'h62;
  localparam logic [7:0] EE_SLOT_P2 = 8'h64;
  localparam logic [7:0] EE_TL_P0 = 8'h68;
  // Values held until a word is loaded (top seven bits of a slot word are the TC map)
  localparam logic [15:0] SLOT_DFLT_P0 = 16'hfe02;
  localparam logic [15:0] SLOT_DFLT_P1 = 16'hfe12;
  localparam logic [15:0] SLOT_DFLT_P2 = 16'hfe22;
  localparam logic [15:0] TL_DFLT_P0 = 16'h0376;
  // Bit positions inside a slot word
  localparam int W_IMPL = 0;
  localparam int W_REFCLK = 1;
  localparam int W_DSI = 2;
  localparam int W_LOW_PRIORITY_VC_COUNT = 3;
  localparam int W_PNUM_LO = 4;
  localparam int W_TC_LO = 9;
  // Bit positions inside the transaction-layer word
  localparam int T_PDIS = 0;
  localparam int T_RSEL = 1;
  localparam int T_CLKPM = 2;
  localparam int T_PCIPM = 4;
  localparam int T_ASPM = 5;
  // Configuration-space offsets
  localparam logic [11:0] CFG_SLOT_CAP = 12'h0c0;
  localparam logic [11:0] CFG_SLOT_CLK = 12'h0d0;
  localparam logic [11:0] CFG_PM_CAP = 12'h040;
  localparam logic [11:0] CFG_VC_CAP = 12'h144;
  localparam logic [11:0] CFG_LINK_CAP = 12'h0cc;
  localparam logic [11:0] CFG_VC0_MAP = 12'h154;
  localparam logic [11:0] CFG_TL_CTRL = 12'h08c;
  localparam logic [11:0] CFG_L1SS_CAP = 12'h244;
  // Bit positions inside configuration-space dwords
  localparam int C_IMPL = 24;
  localparam int C_REFCLK = 28;
  localparam int C_DSI = 21;
  localparam int C_LOW_PRIORITY_VC_COUNT = 4;
  localparam int C_PNUM_LO = 24;
  localparam int C_TC_LO = 1;
  localparam int C_PDIS = 10;
  localparam int C_RSEL = 11;
  localparam int C_CLKPM = 18;
  localparam int C_PCIPM = 1;
  localparam int C_ASPM = 3;
  // APB register byte addresses
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_SLOT0 = 12'h008;
  localparam logic [11:0] A_SLOT1 = 12'h00c;
  localparam logic [11:0] A_SLOT2 = 12'h010;
  localparam logic [11:0] A_TL0 = 12'h014;
  localparam logic CTRL_LOAD_EN_RST = 1'b1;
endpackage

// *** design/spcm_field_if.sv ***
// Interfaces that carry the loaded field values to the mapping logic
interface spcm_slot_if;
  logic slot_impl;
  logic ref_clk;
  logic dsi_req;
  logic low_priority_vc_count;
  logic [2:0] port_num;
  logic [6:0] tc_map;
  modport src (output slot_impl, ref_clk, dsi_req, low_priority_vc_count,
    port_num, tc_map);
  modport dst (input slot_impl, ref_clk, dsi_req, low_priority_vc_count,
    port_num, tc_map);
endinterface

interface spcm_tl_if;
  logic port_disable;
  logic reset_sel;
  logic clock_pm;
  logic pcipm_l1_1_support;
  logic aspm_l1_1_support;
  modport src (output port_disable, reset_sel, clock_pm,
    pcipm_l1_1_support, aspm_l1_1_support);
  modport dst (input port_disable, reset_sel, clock_pm,
    pcipm_l1_1_support, aspm_l1_1_support);
endinterface

// *** design/spcm_slot_map.sv ***
// Holder for one port's slot word, loaded once after reset
module spcm_slot_map #(
  parameter logic [15:0] DFLT = spcm_pkg::SLOT_DFLT_P1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] word_i,
  output logic loaded_o,
  spcm_slot_if.src fld
);
  logic [15:0] word_reg;
  logic loaded_reg;
  wire logic take = load_i & ~loaded_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg <= DFLT;
      loaded_reg <= 1'b0;
    end else if (take) begin
      word_reg <= word_i;
      loaded_reg <= 1'b1;
    end
  end

  // Field split of the stored word
  assign loaded_o = loaded_reg;
  assign fld.slot_impl = word_reg[spcm_pkg::W_IMPL];
  assign fld.ref_clk = word_reg[spcm_pkg::W_REFCLK];
  assign fld.dsi_req = word_reg[spcm_pkg::W_DSI];
  assign fld.low_priority_vc_count = word_reg[spcm_pkg::W_LOW_PRIORITY_VC_COUNT];
  assign fld.port_num = word_reg[spcm_pkg::W_PNUM_LO +: 3];
  assign fld.tc_map = word_reg[spcm_pkg::W_TC_LO +: 7];

  a_slot_dflt_reset: assert property (@(posedge clk_i)
    rst_i |=> (word_reg == DFLT) && !loaded_reg)
    else $error("slot word not at default after reset");
  a_slot_load_cap: assert property (@(posedge clk_i)
    disable iff (rst_i)
    load_i && !loaded_reg |=> word_reg == $past(word_i) && loaded_reg)
    else $error("slot word not captured on first load");
  a_slot_load_once: assert property (@(posedge clk_i)
    disable iff (rst_i) loaded_reg |=> $stable(word_reg) && loaded_reg)
    else $error("slot word changed after it was loaded");
endmodule

// *** design/spcm_tl_map.sv ***
// Holder for the port 0 transaction-layer control word
module spcm_tl_map (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] word_i,
  output logic loaded_o,
  spcm_tl_if.src fld
);
  logic [15:0] word_reg;
  logic loaded_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg <= spcm_pkg::TL_DFLT_P0;
      loaded_reg <= 1'b0;
    end else if (load_i && !loaded_reg) begin
      word_reg <= word_i;
      loaded_reg <= 1'b1;
    end
  end

  // Field split of the stored word
  assign loaded_o = loaded_reg;
  assign fld.port_disable = word_reg[spcm_pkg::T_PDIS];
  assign fld.reset_sel = word_reg[spcm_pkg::T_RSEL];
  assign fld.clock_pm = word_reg[spcm_pkg::T_CLKPM];
  assign fld.pcipm_l1_1_support = word_reg[spcm_pkg::T_PCIPM];
  assign fld.aspm_l1_1_support = word_reg[spcm_pkg::T_ASPM];

  a_tl_dflt_reset: assert property (@(posedge clk_i)
    rst_i |=> word_reg == spcm_pkg::TL_DFLT_P0)
    else $error("control word not at default after reset");
  a_tl_load_once: assert property (@(posedge clk_i)
    disable iff (rst_i) loaded_reg && load_i |=> $stable(word_reg))
    else $error("control word reloaded");
endmodule

// *** design/spcm_top.sv ***
// Top of the EEPROM word to per-port configuration field loader
// What this block does
// - Word 62h bit0 to port1 C0h bit24
// - Word 64h bit0 to port2 C0h bit24
// - Slot word bit1 to D0h bit28
// - Slot word bit2 to 40h bit21
// - Slot word bit3 to 144h bit4
// - Slot word bits6:4 to CCh bits26:24
// - Slot word bits15:9 to 154h bits7:1
// - Port 2 uses port 1 layout
// - Word 68h bits1:0 to 8Ch bits11:10
// - Word 68h bit2 to port0 CCh bit18
// - Word 68h bits5:4 to 244h bits3,1
// - Port 0 slot word is 60h
//
// Decided for this implementation: register access over APB and the register addresses.
module spcm_top (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic EE_WORD_VALID_I,
  input wire logic [7:0] EE_ADDR_I,
  input wire logic [15:0] EE_DATA_I,
  input wire logic EE_LOAD_DONE_I,
  input wire logic CFG_RD_I,
  input wire logic [1:0] CFG_PORT_I,
  input wire logic [11:0] CFG_OFFSET_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_RVALID_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  // Maps one slot word onto the dword at a configuration offset
  function automatic logic [31:0] spcm_slot_cfg(input logic [11:0] off,
                                                input logic [15:0] w);
    logic [31:0] r;
    r = 32'h0;
    case (off)
      spcm_pkg::CFG_SLOT_CAP: r[spcm_pkg::C_IMPL] = w[spcm_pkg::W_IMPL];
      spcm_pkg::CFG_SLOT_CLK: r[spcm_pkg::C_REFCLK] = w[spcm_pkg::W_REFCLK];
      spcm_pkg::CFG_PM_CAP: r[spcm_pkg::C_DSI] = w[spcm_pkg::W_DSI];
      spcm_pkg::CFG_VC_CAP: r[spcm_pkg::C_LOW_PRIORITY_VC_COUNT] = w[spcm_pkg::W_LOW_PRIORITY_VC_COUNT];
      spcm_pkg::CFG_LINK_CAP: begin
        r[spcm_pkg::C_PNUM_LO +: 3] = w[spcm_pkg::W_PNUM_LO +: 3];
      end
      spcm_pkg::CFG_VC0_MAP: begin
        r[spcm_pkg::C_TC_LO +: 7] = w[spcm_pkg::W_TC_LO +: 7];
      end
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // Rebuilds a slot word from its carried fields
  function automatic logic [15:0] spcm_pack(input logic [6:0] tc,
                                            input logic [2:0] pn,
                                            input logic [3:0] low);
    return {tc, 2'b00, pn, low};
  endfunction

  spcm_slot_if slot0 ();
  spcm_slot_if slot1 ();
  spcm_slot_if slot2 ();
  spcm_tl_if tl0 ();

  logic load_en_reg;
  logic done_reg;
  logic [31:0] prdata_reg;
  logic [31:0] cfg_rdata_reg;
  logic cfg_rvalid_reg;
  logic [3:0] loaded;

  // Load strobes per EEPROM word, closed by control bit or end of load
  wire logic ee_open = EE_WORD_VALID_I & load_en_reg & ~done_reg;
  wire logic ld_p0 = ee_open & (EE_ADDR_I == spcm_pkg::EE_SLOT_P0);
  wire logic ld_p1 = ee_open & (EE_ADDR_I == spcm_pkg::EE_SLOT_P1);
  wire logic ld_p2 = ee_open & (EE_ADDR_I == spcm_pkg::EE_SLOT_P2);
  wire logic ld_tl = ee_open & (EE_ADDR_I == spcm_pkg::EE_TL_P0);

  spcm_slot_map #(.DFLT(spcm_pkg::SLOT_DFLT_P0)) u_slot0 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(ld_p0),
    .word_i(EE_DATA_I),
    .loaded_o(loaded[0]),
    .fld(slot0.src)
  );
  spcm_slot_map #(.DFLT(spcm_pkg::SLOT_DFLT_P1)) u_slot1 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(ld_p1),
    .word_i(EE_DATA_I),
    .loaded_o(loaded[1]),
    .fld(slot1.src)
  );
  spcm_slot_map #(.DFLT(spcm_pkg::SLOT_DFLT_P2)) u_slot2 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(ld_p2),
    .word_i(EE_DATA_I),
    .loaded_o(loaded[2]),
    .fld(slot2.src)
  );
  spcm_tl_map u_tl0 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(ld_tl),
    .word_i(EE_DATA_I),
    .loaded_o(loaded[3]),
    .fld(tl0.src)
  );

  // Slot words rebuilt from the field carriers
  wire logic [15:0] w0 = spcm_pack(slot0.tc_map, slot0.port_num,
    {slot0.low_priority_vc_count, slot0.dsi_req, slot0.ref_clk,
     slot0.slot_impl});
  wire logic [15:0] w1 = spcm_pack(slot1.tc_map, slot1.port_num,
    {slot1.low_priority_vc_count, slot1.dsi_req, slot1.ref_clk,
     slot1.slot_impl});
  wire logic [15:0] w2 = spcm_pack(slot2.tc_map, slot2.port_num,
    {slot2.low_priority_vc_count, slot2.dsi_req, slot2.ref_clk,
     slot2.slot_impl});

  // Selection of the addressed port
  wire logic port_ok = (CFG_PORT_I != 2'd3);
  wire logic [15:0] sel_word = (CFG_PORT_I == 2'd0) ? w0 :
                               (CFG_PORT_I == 2'd1) ? w1 :
                               (CFG_PORT_I == 2'd2) ? w2 : 16'h0000;

  // port disable and reset select dword
  wire logic [31:0] tl_ctrl = {20'h0, tl0.reset_sel, tl0.port_disable,
                               10'h000};
  wire logic [31:0] tl_link = {13'h0000, tl0.clock_pm, 18'h00000};
  wire logic [31:0] tl_l1ss = {28'h0000000, tl0.aspm_l1_1_support, 1'b0,
                               tl0.pcipm_l1_1_support, 1'b0};
  wire logic [31:0] tl_cfg =
    (CFG_OFFSET_I == spcm_pkg::CFG_TL_CTRL) ? tl_ctrl :
    (CFG_OFFSET_I == spcm_pkg::CFG_LINK_CAP) ? tl_link :
    (CFG_OFFSET_I == spcm_pkg::CFG_L1SS_CAP) ? tl_l1ss : 32'h0;
  wire logic [31:0] cfg_next = !port_ok ? 32'h0 :
    spcm_slot_cfg(CFG_OFFSET_I, sel_word) |
    ((CFG_PORT_I == 2'd0) ? tl_cfg : 32'h0);

  // Registered configuration read answer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cfg_rdata_reg <= 32'h0;
      cfg_rvalid_reg <= 1'b0;
    end else begin
      cfg_rvalid_reg <= CFG_RD_I;
      if (CFG_RD_I) begin
        cfg_rdata_reg <= cfg_next;
      end
    end
  end
  assign CFG_RDATA_O = cfg_rdata_reg;
  assign CFG_RVALID_O = cfg_rvalid_reg;

  // APB decode
  wire logic apb_setup = PSEL_I & ~PENABLE_I;
  wire logic apb_acc = PSEL_I & PENABLE_I;
  wire logic hit_ctrl = (PADDR_I == spcm_pkg::A_CTRL);
  wire logic hit_stat = (PADDR_I == spcm_pkg::A_STATUS);
  wire logic hit_s0 = (PADDR_I == spcm_pkg::A_SLOT0);
  wire logic hit_s1 = (PADDR_I == spcm_pkg::A_SLOT1);
  wire logic hit_s2 = (PADDR_I == spcm_pkg::A_SLOT2);
  wire logic hit_tl = (PADDR_I == spcm_pkg::A_TL0);
  wire logic mapped = hit_ctrl | hit_stat | hit_s0 | hit_s1 | hit_s2 |
                      hit_tl;
  wire logic [15:0] tl_word = {10'h000, tl0.aspm_l1_1_support,
    tl0.pcipm_l1_1_support, 1'b0, tl0.clock_pm, tl0.reset_sel,
    tl0.port_disable};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {31'h0, load_en_reg} :
    hit_stat ? {27'h0, done_reg, loaded} :
    hit_s0 ? {16'h0, w0} :
    hit_s1 ? {16'h0, w1} :
    hit_s2 ? {16'h0, w2} :
    hit_tl ? {16'h0, tl_word} : 32'h0;

  // Control register and load window; loaded fields are never writable
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      load_en_reg <= spcm_pkg::CTRL_LOAD_EN_RST;
      done_reg <= 1'b0;
    end else begin
      if (apb_acc && PWRITE_I && hit_ctrl) begin
        load_en_reg <= PWDATA_I[0];
      end
      if (EE_LOAD_DONE_I) begin
        done_reg <= 1'b1;
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prdata_reg <= 32'h0;
    end else if (apb_setup) begin
      prdata_reg <= PWRITE_I ? 32'h0 : rd_mux;
    end
  end
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_acc & ~mapped;

  a_c0_slot_p1: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && CFG_PORT_I == 2'd1 && CFG_OFFSET_I == 12'h0c0 |=>
    CFG_RDATA_O[24] == $past(slot1.slot_impl) && CFG_RVALID_O)
    else $error("port 1 slot implemented bit wrong");
  a_c0_slot_p2: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && CFG_PORT_I == 2'd2 && CFG_OFFSET_I == 12'h0c0 |=>
    CFG_RDATA_O[24] == $past(slot2.slot_impl))
    else $error("port 2 slot implemented bit wrong");
  a_d0_ref_clk: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && port_ok && CFG_OFFSET_I == 12'h0d0 |=>
    CFG_RDATA_O == {3'b000, $past(sel_word[1]), 28'h0000000})
    else $error("reference clock bit wrong");
  a_pm_dsi_bit: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && port_ok && CFG_OFFSET_I == 12'h040 |=>
    CFG_RDATA_O[21] == $past(sel_word[2]))
    else $error("device specific init bit wrong");
  a_vc_low_priority_vc_count_bit: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && port_ok && CFG_OFFSET_I == 12'h144 |=>
    CFG_RDATA_O[4] == $past(sel_word[3]))
    else $error("low priority channel bit wrong");
  a_cc_port_num: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && port_ok && CFG_OFFSET_I == 12'h0cc |=>
    CFG_RDATA_O[26:24] == $past(sel_word[6:4]))
    else $error("port number field wrong");
  a_vc0_tc_map: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && port_ok && CFG_OFFSET_I == 12'h154 |=>
    CFG_RDATA_O[7:1] == $past(sel_word[15:9]) && CFG_RDATA_O[0] == 1'b0)
    else $error("traffic class map wrong");
  a_tl_ctrl_map: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && CFG_PORT_I == 2'd0 && CFG_OFFSET_I == 12'h08c |=>
    CFG_RDATA_O[11:10] == $past({tl0.reset_sel, tl0.port_disable}))
    else $error("port disable or reset select wrong");
  a_cc_clock_pm: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && CFG_OFFSET_I == 12'h0cc |=>
    CFG_RDATA_O[18] == ($past(CFG_PORT_I) == 2'd0 && $past(tl0.clock_pm)))
    else $error("clock power management bit wrong");
  a_l1ss_bits: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && CFG_PORT_I == 2'd0 && CFG_OFFSET_I == 12'h244 |=>
    CFG_RDATA_O[3:0] == {$past(tl0.aspm_l1_1_support), 1'b0,
                         $past(tl0.pcipm_l1_1_support), 1'b0})
    else $error("substate support bits wrong");
  a_apb_ro_slot: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    apb_acc && PWRITE_I && !EE_WORD_VALID_I |=> $stable(w1))
    else $error("software write changed a loaded field");
  // Read answer one cycle after the request
  a_rvalid_pulse: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    1'b1 |=> CFG_RVALID_O == $past(CFG_RD_I))
    else $error("configuration read answer not one cycle late");
  a_load_closed: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    done_reg |=> $stable(loaded))
    else $error("word taken after the load finished");
  a_load_off: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !load_en_reg |=> $stable(loaded))
    else $error("word taken while loading was switched off");
  a_ro_no_err: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    apb_acc && PWRITE_I && PADDR_I == 12'h00c |-> !PSLVERR_O)
    else $error("write to a read-only word flagged as error");

  c_load_p1: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ld_p1 ##1 CFG_RD_I && CFG_PORT_I == 2'd1);
  c_load_tl: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ld_tl ##1 loaded[3]);
  c_ctrl_off: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    apb_acc && PWRITE_I && hit_ctrl && !PWDATA_I[0]);
  c_unmapped: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    PSLVERR_O);
  c_dup_refused: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ld_p1 && loaded[1]);
endmodule

// *** testbench/spcm_ee_model.sv ***
// Behavioural stand-in for the serial configuration EEPROM loader
module spcm_ee_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic present_i,
  input wire logic dup_i,
  input wire logic [3:0] gap_i,
  input wire logic [63:0] words_i,
  output logic valid_o,
  output logic [7:0] addr_o,
  output logic [15:0] data_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stream order; the last two entries repeat the port 1 and control words
  localparam logic [7:0] ADR [6] = '{8'h60, 8'h62, 8'h64, 8'h68, 8'h62,
    8'h68};
  // Streams words on request; each idle step inverts the current address and data lines
  always begin
    @(posedge clk_i);
    if (rst_i) begin
      valid_o <= 1'b0;
      addr_o <= 8'h00;
      data_o <= 16'h0000;
      done_o <= 1'b0;
    end else if (go_i) begin
      done_o <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        if (present_i && (i < 4 || dup_i)) begin
          valid_o <= 1'b1;
          addr_o <= ADR[i];
          data_o <= (i == 4) ? ~words_i[31:16] :
            (i == 5) ? ~words_i[63:48] : words_i[16*i +: 16];
          @(posedge clk_i);
          if (gap_i != 4'h0) begin
            valid_o <= 1'b0;
            addr_o <= ~addr_o;
            data_o <= ~data_o;
            repeat (gap_i) @(posedge clk_i);
          end
        end
      end
      valid_o <= 1'b0;
      addr_o <= ~addr_o;
      data_o <= ~data_o;
      @(posedge clk_i);
      done_o <= 1'b1;
    end
  end
endmodule

// *** testbench/spcm_tb_top.sv ***
// Self-checking bench for the EEPROM configuration field loader
module spcm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] OFFS [8] = '{12'h0c0, 12'h0d0, 12'h040,
    12'h144, 12'h0cc, 12'h154, 12'h08c, 12'h244};
  localparam logic [15:0] D0 = spcm_pkg::SLOT_DFLT_P0;
  localparam logic [15:0] D1 = spcm_pkg::SLOT_DFLT_P1;
  localparam logic [15:0] D2 = spcm_pkg::SLOT_DFLT_P2;
  localparam logic [15:0] DT = spcm_pkg::TL_DFLT_P0;
  localparam logic [63:0] WS = 64'h0009_54cb_802d_0175;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic [1:0] port = 2'h0;
  logic [11:0] off = 12'h000;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b0;
  logic pres = 1'b0;
  logic dup = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [63:0] words = 64'h0;
  logic ee_v, ee_done, rvalid, pready, perr;
  logic [7:0] ee_a;
  logic [15:0] ee_d;
  logic [31:0] rdata, prdata;
  int checks = 0;
  int bad_count = 0;
  // Free-running core clock
  always #4 clk = ~clk;
  spcm_top i_spcm_top (.CLK_I(clk), .SYS_RST_I(rst), .EE_WORD_VALID_I(ee_v),
    .EE_ADDR_I(ee_a), .EE_DATA_I(ee_d), .EE_LOAD_DONE_I(ee_done),
    .CFG_RD_I(rd), .CFG_PORT_I(port), .CFG_OFFSET_I(off),
    .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr));
  spcm_ee_model i_spcm_ee_model (.clk_i(clk), .rst_i(rst), .go_i(go),
    .present_i(pres), .dup_i(dup), .gap_i(gap), .words_i(words),
    .valid_o(ee_v), .addr_o(ee_a), .data_o(ee_d), .done_o(ee_done));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    chk(nm, 32'h0, 32'h1);
    print_verdict();
  endtask
  // Expected config dword for one port and offset
  function automatic logic [31:0] exp_cfg(input logic [1:0] p,
    input logic [11:0] o, input logic [15:0] s, t);
    logic [31:0] r;
    r = 32'h0;
    case (o)
      12'h0c0: r[24] = s[0];
      12'h0d0: r[28] = s[1];
      12'h040: r[21] = s[2];
      12'h144: r[4] = s[3];
      12'h0cc: r[26:18] = {s[6:4], 5'h0, (p == 2'h0) & t[2]};
      12'h154: r[7:1] = s[15:9];
      12'h08c: r[11:10] = (p == 2'h0) ? t[1:0] : 2'h0;
      12'h244: r[3:1] = (p == 2'h0) ? {t[5], 1'b0, t[4]} : 3'h0;
      default: r = 32'h0;
    endcase
    return r;
  endfunction
  task automatic reset_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hang("apb ready");
    d = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cfg_read(input logic [1:0] p, input logic [11:0] o,
    output logic [31:0] d);
    int n;
    @(posedge clk);
    rd <= 1'b1;
    port <= p;
    off <= o;
    n = 0;
    do begin
      @(posedge clk);
      rd <= 1'b0;
      #1;
      n++;
    end while (rvalid !== 1'b1 && n < 8);
    if (rvalid !== 1'b1) hang("cfg rvalid");
    d = rdata;
  endtask
  task automatic ee_run(input logic pr, dp, input logic [3:0] g,
    input logic [63:0] ws);
    int n;
    @(posedge clk);
    pres <= pr;
    dup <= dp;
    gap <= g;
    words <= ws;
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      go <= 1'b0;
      #1;
      n++;
    end while (ee_done !== 1'b1 && n < 200);
    if (ee_done !== 1'b1) hang("eeprom done");
  endtask
  task automatic port_chk(input logic [1:0] p, input logic [15:0] s, t);
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      cfg_read(p, OFFS[i], d);
      chk($sformatf("cfg p%0d %h", p, OFFS[i]), d,
        exp_cfg(p, OFFS[i], s, t));
    end
  endtask
  task automatic all_chk(input logic [15:0] s0, s1, s2, t,
    input logic [31:0] st, m);
    logic [31:0] d;
    logic e;
    port_chk(2'h0, s0, t);
    port_chk(2'h1, s1, t);
    port_chk(2'h2, s2, t);
    cfg_read(2'h3, 12'h0c0, d);
    chk("cfg p3", d, 32'h0);
    apb(1'b0, 12'h004, 32'h0, d, e);
    chk("status", d & m, st);
    apb(1'b0, 12'h008, 32'h0, d, e);
    chk("slot0 reg", d, {16'h0, s0 & 16'hfe7f});
    apb(1'b0, 12'h00c, 32'h0, d, e);
    chk("slot1 reg", d, {16'h0, s1 & 16'hfe7f});
    apb(1'b0, 12'h010, 32'h0, d, e);
    chk("slot2 reg", d, {16'h0, s2 & 16'hfe7f});
    apb(1'b0, 12'h014, 32'h0, d, e);
    chk("tl reg", d, {16'h0, t & 16'h0037});
  endtask
  // Defaults after reset, then a start with no EEPROM fitted
  task automatic t_defaults;
    logic [31:0] d;
    logic e;
    reset_dut();
    apb(1'b0, 12'h000, 32'h0, d, e);
    chk("ctrl reset", d, 32'h1);
    all_chk(D0, D1, D2, DT, 32'h0, 32'hff);
    ee_run(1'b0, 1'b0, 4'h0, WS);
    all_chk(D0, D1, D2, DT, 32'h10, 32'hff);
  endtask
  // Loading switched off by software keeps every default
  task automatic t_disabled;
    logic [31:0] d;
    logic e;
    reset_dut();
    apb(1'b1, 12'h000, 32'h0, d, e);
    apb(1'b0, 12'h000, 32'h0, d, e);
    chk("ctrl cleared", d, 32'h0);
    ee_run(1'b1, 1'b0, 4'h2, WS);
    all_chk(D0, D1, D2, DT, 32'h0, 32'h0f);
  endtask
  // Back-to-back load with duplicate port 1 and control words, then refused late traffic
  task automatic t_load;
    logic [31:0] d;
    logic e;
    reset_dut();
    ee_run(1'b1, 1'b1, 4'h0, WS);
    all_chk(16'h0175, 16'h802d, 16'h54cb, 16'h0009, 32'h1f, 32'hff);
    ee_run(1'b1, 1'b0, 4'h3, ~WS);
    apb(1'b1, 12'h00c, 32'hffffffff, d, e);
    chk("ro write err", {31'h0, e}, 32'h0);
    apb(1'b0, 12'h018, 32'h0, d, e);
    chk("unmapped rd err", {31'h0, e}, 32'h1);
    chk("unmapped rd data", d, 32'h0);
    apb(1'b1, 12'h018, 32'h1, d, e);
    chk("unmapped wr err", {31'h0, e}, 32'h1);
    all_chk(16'h0175, 16'h802d, 16'h54cb, 16'h0009, 32'h1f, 32'hff);
  endtask
  // Main sequence
  initial begin
    t_defaults();
    t_disabled();
    t_load();
    print_verdict();
  end
endmodule
